/* File: logic/cjm_exec.sv */
`timescale 1ns/1ps
module cjm_exec
  import cjm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // instruction request, from core logic on this clock
  input wire logic req_valid,
  input wire cjm_req_s req,
  // status register load from core (e.g. after an alu op)
  input wire logic sr_load,
  input wire logic [WORD_W-1:0] sr_load_val,
  // architectural results
  output logic [PC_W-1:0] pc,
  output logic [WORD_W-1:0] sr,
  output logic wr_en,
  output logic [REG_IDX_W-1:0] wr_idx,
  output logic [WORD_W-1:0] wr_val,
  output logic [WORD_W-1:0] src_keep,
  output logic taken,
  output logic done
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  cjm_state_s st_q;
  cjm_state_s st_d;
  logic cond;
  logic [PC_W-1:0] disp;
  logic [PC_W-1:0] seq_pc;

  // pc register holds the address of the next instruction already
  assign seq_pc = st_q.pc;
  // offset doubled then sign extended to full address width
  assign disp = {{(PC_W-OFS_W-1){req.offset[OFS_W-1]}}, req.offset, 1'b0};

  always_comb begin
    cond = 1'b0;
    // flags read from the current status register, not any in-flight value
    case (req.op)
      CJM_OP_JUMP_IF_LESS_SIGNED: cond = st_q.sr[SR_N] ^ st_q.sr[SR_V];
      CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED: cond = ~(st_q.sr[SR_N] ^ st_q.sr[SR_V]);
      CJM_OP_UNCONDITIONAL_JUMP: cond = 1'b1;
      CJM_OP_JUMP_IF_NEGATIVE: cond = st_q.sr[SR_N];
      CJM_OP_JUMP_IF_CARRY_CLEAR: cond = ~st_q.sr[SR_C];
      CJM_OP_JUMP_IF_ZERO_CLEAR: cond = ~st_q.sr[SR_Z];
      default: cond = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.wr_en = 1'b0;
    st_d.done = 1'b0;
    st_d.taken = 1'b0;
    // sr untouched by every op here; only an explicit core load changes it
    if (sr_load) begin
      st_d.sr = sr_load_val;
    end
    if (req_valid) begin
      st_d.done = 1'b1;
      case (req.op)
        CJM_OP_COPY_OPERAND: begin
          st_d.wr_en = 1'b1;
          st_d.wr_idx = req.dst_idx;
          st_d.src_keep = req.src_val;
          // byte form: low byte moved, high byte of a register clears
          if (req.byte_mode) begin
            st_d.wr_val = {{(WORD_W-BYTE_W){1'b0}}, req.src_val[BYTE_W-1:0]};
          end else begin
            st_d.wr_val = req.src_val;
          end
          st_d.pc = seq_pc + INSN_STEP;
        end
        CJM_OP_IDLE_INSTRUCTION: begin
          // write to the constant register is discarded: no visible effect
          st_d.wr_en = 1'b0;
          st_d.wr_idx = CG_REG_IDX;
          st_d.wr_val = WORD_ZERO;
          st_d.pc = seq_pc + INSN_STEP;
        end
        CJM_OP_NONE: begin
          st_d.pc = seq_pc + INSN_STEP;
        end
        default: begin
          st_d.taken = cond;
          if (cond) begin
            st_d.pc = seq_pc + disp;
          end else begin
            st_d.pc = seq_pc + INSN_STEP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q.pc <= PC_RST;
      st_q.sr <= SR_RST;
      st_q.wr_en <= 1'b0;
      st_q.wr_idx <= '0;
      st_q.wr_val <= WORD_ZERO;
      st_q.src_keep <= WORD_ZERO;
      st_q.taken <= 1'b0;
      st_q.done <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pc = st_q.pc;
  assign sr = st_q.sr;
  assign wr_en = st_q.wr_en;
  assign wr_idx = st_q.wr_idx;
  assign wr_val = st_q.wr_val;
  assign src_keep = st_q.src_keep;
  assign taken = st_q.taken;
  assign done = st_q.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_jump(cjm_op_e o);
    req_valid && !sr_load && req.op == o;
  endsequence

  // any of the flag-tested relative jumps
  sequence s_cond_jump;
    req_valid && (req.op == CJM_OP_JUMP_IF_LESS_SIGNED
      || req.op == CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED
      || req.op == CJM_OP_JUMP_IF_NEGATIVE
      || req.op == CJM_OP_JUMP_IF_CARRY_CLEAR
      || req.op == CJM_OP_JUMP_IF_ZERO_CLEAR);
  endsequence

  sequence s_copy;
    req_valid && req.op == CJM_OP_COPY_OPERAND;
  endsequence

  // ----------------------------------------
  // checks: decisions and targets
  // ----------------------------------------
  // decisions compare against the status one edge back, before any load lands

  chk_less_taken: assert property (
    s_jump(CJM_OP_JUMP_IF_LESS_SIGNED) |=> taken == $past(sr[SR_N] ^ sr[SR_V]))
    else $error("signed-less decision wrong");
  chk_ge_taken: assert property (
    s_jump(CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED) |=> taken == !$past(sr[SR_N] ^ sr[SR_V]))
    else $error("signed greater-equal decision wrong");
  chk_target_calc: assert property (
    req_valid && req.op == CJM_OP_UNCONDITIONAL_JUMP
    |=> pc == $past(pc) + {{(PC_W-OFS_W-1){$past(req.offset[OFS_W-1])}},
      $past(req.offset), 1'b0})
    else $error("jump target wrong");
  chk_cond_target: assert property (
    s_cond_jump ##1 taken
    |-> pc == $past(pc) + {{(PC_W-OFS_W-1){$past(req.offset[OFS_W-1])}},
      $past(req.offset), 1'b0})
    else $error("conditional jump target wrong");
  chk_uncond_taken: assert property (
    req_valid && req.op == CJM_OP_UNCONDITIONAL_JUMP |=> taken && done)
    else $error("unconditional jump not taken");
  chk_neg_taken: assert property (
    s_jump(CJM_OP_JUMP_IF_NEGATIVE) |=> taken == $past(sr[SR_N]))
    else $error("negative jump decision wrong");
  chk_carry_clear: assert property (
    s_jump(CJM_OP_JUMP_IF_CARRY_CLEAR) |=> taken == !$past(sr[SR_C]))
    else $error("carry-clear decision wrong");
  chk_zero_clear: assert property (
    s_jump(CJM_OP_JUMP_IF_ZERO_CLEAR) |=> taken == !$past(sr[SR_Z]))
    else $error("zero-clear decision wrong");
  chk_flags_kept: assert property (
    req_valid && !sr_load |=> $stable(sr))
    else $error("status changed by jump, copy or idle");
  chk_fallthrough: assert property (
    s_cond_jump ##1 !taken |-> pc == $past(pc) + INSN_STEP)
    else $error("not-taken jump did not fall through");
  chk_mode_kept: assert property (
    req_valid && !sr_load
    |=> $stable(sr[SR_GIE]) && $stable(sr[SR_PROCESSOR_HALT_BIT]) && $stable(sr[SR_OSCILLATOR_DISABLE_BIT]))
    else $error("mode bits changed by an instruction");
  chk_copy_flags: assert property (
    s_jump(CJM_OP_COPY_OPERAND)
    |=> $stable(sr[SR_N]) && $stable(sr[SR_Z]) && $stable(sr[SR_C]) && $stable(sr[SR_V]))
    else $error("copy changed an arithmetic flag");

  // ----------------------------------------
  // checks: copy and idle results
  // ----------------------------------------
  chk_copy_word: assert property (
    req_valid && req.op == CJM_OP_COPY_OPERAND && !req.byte_mode
    |=> wr_en && wr_val == $past(req.src_val) && src_keep == $past(req.src_val))
    else $error("word copy wrong");
  chk_copy_byte: assert property (
    req_valid && req.op == CJM_OP_COPY_OPERAND && req.byte_mode
    |=> wr_en
      && wr_val == {{(WORD_W-BYTE_W){1'b0}}, $past(req.src_val[BYTE_W-1:0])})
    else $error("byte copy wrong");
  chk_idle_noeff: assert property (
    req_valid && req.op == CJM_OP_IDLE_INSTRUCTION |=> !wr_en && !taken)
    else $error("idle had an effect");
  chk_idle_pc: assert property (
    s_jump(CJM_OP_IDLE_INSTRUCTION) |=> pc == $past(pc) + INSN_STEP && $stable(sr))
    else $error("idle moved pc wrongly or touched status");
  chk_copy_src: assert property (
    s_copy |=> wr_idx == $past(req.dst_idx) && src_keep == $past(req.src_val))
    else $error("copy destination or kept source wrong");
  // every accepted request answers with exactly one done pulse, one edge later
  chk_done_pulse: assert property (
    done == $past(req_valid))
    else $error("done pulse does not follow the request");

endmodule

/* File: logic/cjm_pkg.sv */
package cjm_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PC_W = 20;
  localparam int OFS_W = 10;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_IDX_W = 4;

  // ----------------------------------------
  // status register field positions
  // ----------------------------------------
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_GIE = 3;
  localparam int SR_PROCESSOR_HALT_BIT = 4;
  localparam int SR_OSCILLATOR_DISABLE_BIT = 5;
  localparam int SR_V = 8;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 20'h0_0000;
  localparam logic [WORD_W-1:0] SR_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [REG_IDX_W-1:0] CG_REG_IDX = 4'h3;
  localparam logic [PC_W-1:0] INSN_STEP = 20'h0_0002;

  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    CJM_OP_NONE,
    CJM_OP_JUMP_IF_LESS_SIGNED,
    CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED,
    CJM_OP_UNCONDITIONAL_JUMP,
    CJM_OP_JUMP_IF_NEGATIVE,
    CJM_OP_JUMP_IF_CARRY_CLEAR,
    CJM_OP_JUMP_IF_ZERO_CLEAR,
    CJM_OP_COPY_OPERAND,
    CJM_OP_IDLE_INSTRUCTION
  } cjm_op_e;

  typedef struct packed {
    cjm_op_e op;
    logic [OFS_W-1:0] offset;
    logic byte_mode;
    logic [REG_IDX_W-1:0] dst_idx;
    logic [WORD_W-1:0] src_val;
    logic [WORD_W-1:0] dst_old;
  } cjm_req_s;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [WORD_W-1:0] sr;
    logic wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [WORD_W-1:0] wr_val;
    logic [WORD_W-1:0] src_keep;
    logic taken;
    logic done;
  } cjm_state_s;

endpackage

/* File: test/cjm_exec_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module cjm_exec_test;
  import cjm_pkg::*;
  logic core_clk, nrst, req_valid, sr_load, wr_en, taken, done;
  cjm_req_s req;
  logic [WORD_W-1:0] sr_load_val, sr, wr_val, src_keep;
  logic [PC_W-1:0] pc, p;
  logic [REG_IDX_W-1:0] wr_idx;
  int n_fail, n_checks;
  cjm_exec cjm_exec_i(.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .sr_load(sr_load), .sr_load_val(sr_load_val), .pc(pc), .sr(sr), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_val(wr_val), .src_keep(src_keep), .taken(taken), .done(done));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // --------
  // drivers
  // --------
  task automatic load_sr(input logic [WORD_W-1:0] v);
    @(posedge core_clk);
    sr_load <= 1'b1;
    sr_load_val <= v;
    @(posedge core_clk);
    sr_load <= 1'b0;
    #1;
  endtask
  // answer is due exactly one edge after the request
  task automatic run(input cjm_op_e op, input logic [OFS_W-1:0] ofs, input logic bm,
      input logic [WORD_W-1:0] src, input logic ld, input logic [WORD_W-1:0] ldv);
    p = pc;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op, ofs, bm, 4'h5, src, 16'h0000};
    sr_load <= ld;
    sr_load_val <= ldv;
    @(posedge core_clk);
    req_valid <= 1'b0;
    sr_load <= 1'b0;
    #1;
    `CHK("done", 1'b1, done)
  endtask
  function automatic logic [PC_W-1:0] tgt(input logic [OFS_W-1:0] o);
    return p + {{(PC_W-OFS_W-1){o[OFS_W-1]}}, o, 1'b0};
  endfunction
  // --------
  // scenarios
  // --------
  task automatic t_cond;
    cjm_op_e ops[10] = '{CJM_OP_JUMP_IF_LESS_SIGNED, CJM_OP_JUMP_IF_LESS_SIGNED,
      CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED, CJM_OP_JUMP_IF_GREATER_EQUAL_SIGNED,
      CJM_OP_JUMP_IF_NEGATIVE, CJM_OP_JUMP_IF_NEGATIVE, CJM_OP_JUMP_IF_CARRY_CLEAR,
      CJM_OP_JUMP_IF_CARRY_CLEAR, CJM_OP_JUMP_IF_ZERO_CLEAR, CJM_OP_JUMP_IF_ZERO_CLEAR};
    logic [WORD_W-1:0] srs[10] = '{16'h0100, 16'h0104, 16'h0104, 16'h0004, 16'h003C,
      16'h0103, 16'h0106, 16'h0039, 16'h013D, 16'h0002};
    logic tk[10] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
    for (int i = 0; i < 10; i++) begin
      load_sr(srs[i]);
      run(ops[i], 10'h005, 1'b0, 16'h0000, 1'b0, 16'h0000);
      `CHK("taken", tk[i], taken)
      `CHK("pc", tk[i] ? tgt(10'h005) : p + INSN_STEP, pc)
      `CHK("sr", srs[i], sr)
    end
    $display("conditional jumps finished");
  endtask
  task automatic t_jump;
    logic [OFS_W-1:0] ofs[2] = '{10'h1FF, 10'h201};
    load_sr(16'h0138);
    foreach (ofs[i]) begin
      run(CJM_OP_UNCONDITIONAL_JUMP, ofs[i], 1'b0, 16'h0000, 1'b0, 16'h0000);
      `CHK("taken", 1'b1, taken)
      `CHK("pc", tgt(ofs[i]), pc)
      `CHK("sr", 16'h0138, sr)
    end
    $display("span jumps finished");
  endtask
  task automatic t_copy;
    load_sr(16'h013F);
    run(CJM_OP_COPY_OPERAND, 10'h000, 1'b0, 16'hA5C3, 1'b0, 16'h0000);
    `CHK("wr_en", 1'b1, wr_en)
    `CHK("wr_idx", 4'h5, wr_idx)
    `CHK("wr_val", 16'hA5C3, wr_val)
    run(CJM_OP_COPY_OPERAND, 10'h000, 1'b1, 16'h8F7E, 1'b0, 16'h0000);
    `CHK("wr_en", 1'b1, wr_en)
    `CHK("wr_val", 16'h007E, wr_val)
    `CHK("src_keep", 16'h8F7E, src_keep)
    `CHK("pc", p + INSN_STEP, pc)
    `CHK("sr", 16'h013F, sr)
    $display("copies finished");
  endtask
  task automatic t_idle;
    load_sr(16'h0107);
    run(CJM_OP_IDLE_INSTRUCTION, 10'h3FF, 1'b0, 16'hFFFF, 1'b0, 16'h0000);
    `CHK("wr_en", 1'b0, wr_en)
    `CHK("wr_idx", CG_REG_IDX, wr_idx)
    `CHK("wr_val", WORD_ZERO, wr_val)
    `CHK("pc", p + INSN_STEP, pc)
    `CHK("sr", 16'h0107, sr)
    run(CJM_OP_NONE, 10'h3FF, 1'b0, 16'h0000, 1'b0, 16'h0000);
    `CHK("taken", 1'b0, taken)
    `CHK("pc", p + INSN_STEP, pc)
    `CHK("sr", 16'h0107, sr)
    $display("idle finished");
  endtask
  // a status load in the same cycle must not steer the decision
  task automatic t_late;
    load_sr(16'h0004);
    run(CJM_OP_JUMP_IF_NEGATIVE, 10'h010, 1'b0, 16'h0000, 1'b1, 16'h0001);
    `CHK("taken", 1'b1, taken)
    `CHK("sr", 16'h0001, sr)
    run(CJM_OP_JUMP_IF_CARRY_CLEAR, 10'h010, 1'b0, 16'h0000, 1'b1, 16'h0000);
    `CHK("taken", 1'b0, taken)
    $display("late status load finished");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    sr_load = 1'b0;
    sr_load_val = '0;
    repeat (4) @(posedge core_clk);
    `CHK("pc", PC_RST, pc)
    `CHK("sr", SR_RST, sr)
    nrst <= 1'b1;
    t_cond();
    t_jump();
    t_copy();
    t_idle();
    t_late();
    final_report();
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
